// [hdl/eag_top.sv]
/*
 * Effective address generator top.
 * Forms data addresses per mode.
 * X and Y circular correction.
 * Bit-reversed write addressing.
 * Sixteen working registers.
 * Registers behind Avalon-MM.
 * Assumes one request per cycle.
 */
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module eag_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [eag_pkg::EAG_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire eag_pkg::eag_req_t addrReq,
    input wire eag_pkg::eag_wr_t regWrite,
    output eag_pkg::eag_rsp_t addrRsp
);
    import eag_pkg::*;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : mergeLanes

    function automatic logic selActive(input logic en,
                                       input logic [3:0] sel,
                                       input logic [3:0] ptr);
        return en && (sel != EAG_SEL_OFF) && (sel == ptr);
    endfunction : selActive

    eag_state_t stReg;
    eag_state_t stNext;

    // ------------------------------------------------------------------
    // address datapath
    // ------------------------------------------------------------------
    eag_mode_t mode;
    logic [3:0] ptr;
    logic [15:0] ptrVal;
    logic [15:0] offVal;
    logic isMac;
    logic ySpace;
    logic [15:0] macMag;
    logic [15:0] step;
    logic stepNeg;
    logic [15:0] modNext;
    logic [15:0] modIn;
    logic modNeg;
    logic modeMods;
    logic xModOn;
    logic yModOn;
    logic [15:0] xCorr;
    logic [15:0] yCorr;
    logic [15:0] corr;
    logic revOn;
    logic [15:0] revAddr;
    eag_rsp_t rspCalc;

    // RULE7 - per-side mode, shared offset
    assign mode = addrReq.useDst ? addrReq.dstMode : addrReq.srcMode;
    assign ptr = addrReq.useDst ? addrReq.ptrDst : addrReq.ptrSrc;
    assign ptrVal = stReg.default_working_register[ptr];
    assign offVal = stReg.default_working_register[addrReq.offReg];
    assign isMac = addrReq.cls == CLS_MAC;
    // RULE8 - upper prefetch pair to Y
    assign ySpace = isMac && ptr[1];
    // RULE10 - step of 2, 4 or 6 bytes
    assign macMag = {13'h0000, addrReq.macStep, 1'b0};
    assign step = !isMac ? addrReq.modifier :
                  (addrReq.modifier[15] ? 16'h0000 - macMag : macMag);
    assign stepNeg = step[15];
    assign modNext = ptrVal + step;
    assign modeMods = (mode == MD_POST) || (mode == MD_PRE) ||
                      (mode == MD_INDEXED);
    assign modIn = (mode == MD_INDEXED) ? ptrVal + offVal : modNext;
    assign modNeg = (mode == MD_INDEXED) ? offVal[15] : stepNeg;

    // RULE18 - X unit select and enable
    assign xModOn = modeMods && !ySpace &&
        selActive(stReg.modeCtrl[EAG_XEN_BIT],
                  stReg.modeCtrl[EAG_XSEL_LSB+:4], ptr);
    // RULE19 - Y unit select and enable
    assign yModOn = modeMods && ySpace &&
        selActive(stReg.modeCtrl[EAG_YEN_BIT],
                  stReg.modeCtrl[EAG_YSEL_LSB+:4], ptr);

    // RULE12 - independent X and Y buffers
    eag_modulo_unit xModulo (
        .enable(xModOn),
        .wordOnly(1'b0),
        .stepNeg(modNeg),
        .addrIn(modIn),
        .startAddr(stReg.xStart),
        .endAddr(stReg.xEnd),
        .addrOut(xCorr)
    );

    eag_modulo_unit yModulo (
        .enable(yModOn),
        .wordOnly(1'b1),
        .stepNeg(modNeg),
        .addrIn(modIn),
        .startAddr(stReg.yStart),
        .endAddr(stReg.yEnd),
        .addrOut(yCorr)
    );

    assign corr = ySpace ? yCorr : xCorr;

    // RULE22 - X unit, word writes, increments only
    assign revOn = !ySpace && addrReq.isWrite && !addrReq.isByte &&
        ((mode == MD_PRE) || (mode == MD_POST)) &&
        !stepNeg && (step != 16'h0000) &&
        selActive(stReg.revMod[EAG_REN_BIT],
                  stReg.modeCtrl[EAG_RSEL_LSB+:4], ptr);

    eag_bitrev_unit revUnit (
        .ptrIn(ptrVal),
        .modWords(stReg.revMod[14:0]),
        .addrOut(revAddr)
    );

    always_comb begin
        rspCalc = '0;
        rspCalc.valid = addrReq.valid;
        rspCalc.ySpace = ySpace;
        rspCalc.ptrIdx = ptr;
        rspCalc.ptrValue = ptrVal;
        rspCalc.memAccess = 1'b1;
        // RULE4 - first source read directly
        rspCalc.baseValue = stReg.default_working_register[addrReq.baseReg];
        // RULE2 - implicit working operand
        rspCalc.workValue = stReg.default_working_register[EAG_WORK_REG];
        case (mode)
            MD_DIRECT: begin
                rspCalc.memAccess = 1'b0;
            end
            MD_FILE: begin
                // RULE3 - move spans whole space
                if (addrReq.cls == CLS_MOVE) begin
                    rspCalc.ea = addrReq.literal;
                end else begin
                    // RULE1 - near region only
                    rspCalc.ea = {3'b000, addrReq.fileAddr};
                end
            end
            MD_IND: begin
                rspCalc.ea = ptrVal;
            end
            MD_POST: begin
                // RULE5 - old pointer, then modify
                rspCalc.ea = ptrVal;
                rspCalc.ptrWe = 1'b1;
                // RULE23 - reversal takes precedence
                rspCalc.ptrValue = revOn ? revAddr : corr;
            end
            MD_PRE: begin
                // RULE5 - modify, then use
                rspCalc.ptrWe = 1'b1;
                rspCalc.ptrValue = revOn ? revAddr : corr;
                rspCalc.ea = rspCalc.ptrValue;
            end
            MD_INDEXED: begin
                // RULE21 - corrected access, pointer kept
                rspCalc.ea = corr;
            end
            MD_LITOFF: begin
                // RULE6 - pointer plus literal
                rspCalc.ea = ptrVal + addrReq.literal;
            end
            MD_LIT: begin
                rspCalc.memAccess = 1'b0;
                if (addrReq.cls == CLS_MCU) begin
                    rspCalc.litValue = {11'h000,
                        addrReq.literal[EAG_SHORT_LIT_BITS-1:0]};
                end else begin
                    rspCalc.litValue = addrReq.literal;
                end
            end
            default: begin
                rspCalc.err = 1'b1;
            end
        endcase
        // RULE11 - branch and hold literals
        if (addrReq.cls == CLS_BRANCH) begin
            rspCalc.memAccess = 1'b0;
            rspCalc.litValue = addrReq.literal;
        end else if (addrReq.cls == CLS_HOLD) begin
            rspCalc.memAccess = 1'b0;
            rspCalc.litValue = {2'b00,
                addrReq.literal[EAG_HOLD_LIT_BITS-1:0]};
        end
        rspCalc.modApplied = (xModOn || yModOn) && !revOn;
        rspCalc.revApplied = revOn;
        if (isMac) begin
            // RULE8 - only prefetch pointers 8..11
            if (ptr[3:2] != EAG_PREFETCH_GRP) begin
                rspCalc.err = 1'b1;
            end
            // RULE10 - indirect, post by 2/4/6, indexed
            if (!((mode == MD_IND) || (mode == MD_INDEXED) ||
                  ((mode == MD_POST) && (addrReq.macStep != 2'b00)))) begin
                rspCalc.err = 1'b1;
            end
            // RULE9 - indexing only on 9 and 11
            if ((mode == MD_INDEXED) && !ptr[0]) begin
                rspCalc.err = 1'b1;
            end
        end
        if ((addrReq.cls == CLS_MCU) &&
            ((mode == MD_INDEXED) || (mode == MD_LITOFF))) begin
            rspCalc.err = 1'b1;
        end
        if ((addrReq.cls == CLS_FILE) && (mode != MD_FILE)) begin
            rspCalc.err = 1'b1;
        end
        if (rspCalc.err) begin
            rspCalc.ptrWe = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // state update
    // ------------------------------------------------------------------
    always_comb begin
        stNext = stReg;
        stNext.rsp = rspCalc;
        stNext.ack = (avs_read || avs_write) && !stReg.ack;
        if (addrReq.valid) begin
            stNext.lastEa = rspCalc.ea;
            if (rspCalc.ptrWe) begin
                stNext.default_working_register[rspCalc.ptrIdx] = rspCalc.ptrValue;
            end
        end
        if (regWrite.en) begin
            stNext.default_working_register[regWrite.idx] = regWrite.data;
        end
        if (avs_write && stReg.ack) begin
            case (avs_address)
                EAG_OFS_MODE_CTRL: begin
                    stNext.modeCtrl = mergeLanes(stReg.modeCtrl,
                        avs_writedata, avs_byteenable);
                end
                EAG_OFS_X_START: begin
                    stNext.xStart = mergeLanes(stReg.xStart,
                        avs_writedata, avs_byteenable);
                end
                EAG_OFS_X_END: begin
                    stNext.xEnd = mergeLanes(stReg.xEnd,
                        avs_writedata, avs_byteenable);
                end
                EAG_OFS_Y_START: begin
                    stNext.yStart = mergeLanes(stReg.yStart,
                        avs_writedata, avs_byteenable);
                end
                EAG_OFS_Y_END: begin
                    stNext.yEnd = mergeLanes(stReg.yEnd,
                        avs_writedata, avs_byteenable);
                end
                EAG_OFS_REV_MOD: begin
                    stNext.revMod = mergeLanes(stReg.revMod,
                        avs_writedata, avs_byteenable);
                end
                default: begin
                    stNext.lastEa = stNext.lastEa;
                end
            endcase
        end
        if (avs_read && !stReg.ack) begin
            case (avs_address)
                EAG_OFS_MODE_CTRL: stNext.rdata = {16'h0000, stReg.modeCtrl};
                EAG_OFS_X_START: stNext.rdata = {16'h0000, stReg.xStart};
                EAG_OFS_X_END: stNext.rdata = {16'h0000, stReg.xEnd};
                EAG_OFS_Y_START: stNext.rdata = {16'h0000, stReg.yStart};
                EAG_OFS_Y_END: stNext.rdata = {16'h0000, stReg.yEnd};
                EAG_OFS_REV_MOD: stNext.rdata = {16'h0000, stReg.revMod};
                EAG_OFS_LAST_EA: stNext.rdata = {16'h0000, stReg.lastEa};
                default: stNext.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stReg <= '0;
            stReg.modeCtrl <= EAG_RST_MODE_CTRL;
            stReg.xStart <= EAG_RST_ADDR;
            stReg.xEnd <= EAG_RST_ADDR;
            stReg.yStart <= EAG_RST_ADDR;
            stReg.yEnd <= EAG_RST_ADDR;
            stReg.revMod <= EAG_RST_REV_MOD;
        end else begin
            stReg <= stNext;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !stReg.ack;
    assign avs_readdata = stReg.rdata;
    assign addrRsp = stReg.rsp;

endmodule : eag_top

// [hdl/eag_pkg.sv]
/*
 * Constants, enumerations and carriers of the address generator.
 * Assumes one address request per core cycle.
 */
// Summary of operation
// RULE1 - file operands carry 13-bit near address
// RULE2 - file operations use working register zero
// RULE3 - data move reaches the whole data space
// RULE4 - first source direct register, second memory/literal
// RULE5 - post uses old pointer, pre uses modified
// RULE6 - indexed and literal offset add to pointer
// RULE7 - move modes differ, one shared offset field
// RULE8 - prefetch pointers 8..11 split X and Y
// RULE9 - prefetch indexing only registers 9 and 11
// RULE10 - prefetch: indirect, indexed, post step 2/4/6
// RULE11 - branch 16-bit signed, hold 14-bit literal
// RULE12 - one circular buffer each in X, Y
// RULE13 - software avoids frame and stack pointers
// RULE14 - power-of-two buffers check both boundaries
// RULE15 - 16-bit start/end registers imply length
// RULE16 - buffer lengths up to 64 Kbytes
// RULE17 - Y circular addresses are word aligned
// RULE18 - X circular on when select valid, enabled
// RULE19 - Y circular on when select valid, enabled
// RULE20 - beyond-bound compare on active boundary
// RULE21 - write back only for pre/post modes
// RULE22 - bit reversal: X writes, modifier reversed
// RULE23 - bit reversal wins over circular on writes
// RULE24 - wrap adds or subtracts buffer length
package eag_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned EAG_ADDR_W = 5;
    localparam logic [4:0] EAG_OFS_MODE_CTRL = 5'h00;
    localparam logic [4:0] EAG_OFS_X_START = 5'h04;
    localparam logic [4:0] EAG_OFS_X_END = 5'h08;
    localparam logic [4:0] EAG_OFS_Y_START = 5'h0c;
    localparam logic [4:0] EAG_OFS_Y_END = 5'h10;
    localparam logic [4:0] EAG_OFS_REV_MOD = 5'h14;
    localparam logic [4:0] EAG_OFS_LAST_EA = 5'h18;

    localparam logic [15:0] EAG_RST_MODE_CTRL = 16'h0fff;
    localparam logic [15:0] EAG_RST_ADDR = 16'h0000;
    localparam logic [15:0] EAG_RST_REV_MOD = 16'h0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned EAG_XSEL_LSB = 0;
    localparam int unsigned EAG_YSEL_LSB = 4;
    localparam int unsigned EAG_RSEL_LSB = 8;
    localparam int unsigned EAG_XEN_BIT = 15;
    localparam int unsigned EAG_YEN_BIT = 14;
    localparam int unsigned EAG_REN_BIT = 15;
    localparam logic [3:0] EAG_SEL_OFF = 4'hf;
    localparam logic [3:0] EAG_WORK_REG = 4'h0;
    localparam logic [1:0] EAG_PREFETCH_GRP = 2'h2;
    localparam int unsigned EAG_NEAR_BITS = 13;
    localparam int unsigned EAG_SHORT_LIT_BITS = 5;
    localparam int unsigned EAG_HOLD_LIT_BITS = 14;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_FILE, CLS_MCU, CLS_MOVE, CLS_MAC, CLS_BRANCH, CLS_HOLD
    } eag_cls_t;

    typedef enum logic [2:0] {
        MD_DIRECT, MD_FILE, MD_IND, MD_POST, MD_PRE, MD_INDEXED,
        MD_LITOFF, MD_LIT
    } eag_mode_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        eag_cls_t cls;
        eag_mode_t srcMode;
        eag_mode_t dstMode;
        logic useDst;
        logic [3:0] ptrSrc;
        logic [3:0] ptrDst;
        logic [3:0] offReg;
        logic [3:0] baseReg;
        logic [15:0] modifier;
        logic [1:0] macStep;
        logic [EAG_NEAR_BITS-1:0] fileAddr;
        logic [15:0] literal;
        logic isWrite;
        logic isByte;
    } eag_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] ea;
        logic memAccess;
        logic ySpace;
        logic [15:0] baseValue;
        logic [15:0] workValue;
        logic ptrWe;
        logic [3:0] ptrIdx;
        logic [15:0] ptrValue;
        logic [15:0] litValue;
        logic modApplied;
        logic revApplied;
        logic err;
    } eag_rsp_t;

    typedef struct packed {
        logic en;
        logic [3:0] idx;
        logic [15:0] data;
    } eag_wr_t;

    typedef struct packed {
        logic [15:0] modeCtrl;
        logic [15:0] xStart;
        logic [15:0] xEnd;
        logic [15:0] yStart;
        logic [15:0] yEnd;
        logic [15:0] revMod;
        logic [15:0] lastEa;
        logic ack;
        logic [31:0] rdata;
        logic [15:0][15:0] default_working_register;
        eag_rsp_t rsp;
    } eag_state_t;

endpackage : eag_pkg

// [hdl/eag_modulo_unit.sv]
/*
 * Circular correction for one address space; combinational.
 */
`timescale 1ns/1ps
module eag_modulo_unit (
    input wire logic enable,
    input wire logic wordOnly,
    input wire logic stepNeg,
    input wire logic [15:0] addrIn,
    input wire logic [15:0] startAddr,
    input wire logic [15:0] endAddr,
    output logic [15:0] addrOut
);
    logic [16:0] bufLen;
    logic [16:0] lenLess;
    logic isPow2;
    logic aboveEnd;
    logic belowStart;
    logic [15:0] wrapped;

    // RULE15 RULE16 - length from bounds
    assign bufLen = {1'b0, endAddr} - {1'b0, startAddr} + 17'h00001;
    assign lenLess = bufLen - 17'h00001;
    // RULE14 - power-of-two detect
    assign isPow2 = (bufLen & lenLess) == 17'h00000;
    // RULE20 - beyond-bound compare
    assign aboveEnd = addrIn > endAddr;
    assign belowStart = addrIn < startAddr;

    always_comb begin
        wrapped = addrIn;
        // RULE24 - wrap by buffer length
        if (enable && aboveEnd && (!stepNeg || isPow2)) begin
            wrapped = addrIn - bufLen[15:0];
        end else if (enable && belowStart && (stepNeg || isPow2)) begin
            wrapped = addrIn + bufLen[15:0];
        end
        // RULE17 - word aligned result
        if (enable && wordOnly) begin
            wrapped[0] = 1'b0;
        end
        addrOut = wrapped;
    end
endmodule : eag_modulo_unit

// [hdl/eag_bitrev_unit.sv]
/*
 * Bit-reversed pointer advance for word writes; combinational.
 */
`timescale 1ns/1ps
module eag_bitrev_unit (
    input wire logic [15:0] ptrIn,
    input wire logic [14:0] modWords,
    output logic [15:0] addrOut
);
    logic [14:0] revSum;

    function automatic logic [14:0] rev15(input logic [14:0] v);
        logic [14:0] r;
        r = 15'h0000;
        for (int i = 0; i < 15; i++) begin
            r[i] = v[14-i];
        end
        return r;
    endfunction : rev15

    // RULE22 - pointer and modifier reversed, summed, result reversed back
    assign revSum = rev15(ptrIn[15:1]) + rev15(modWords);
    assign addrOut = {rev15(revSum), 1'b0};
endmodule : eag_bitrev_unit

// [tb/eag_top_asserts.sv]
/* port checks for the address generator top.
   assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module eag_top_asserts
    import eag_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire eag_req_t addrReq,
    input wire eag_rsp_t addrRsp
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_busStart;
        (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence
    sequence s_oneWait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    property p_waitOne;
        s_busStart |-> s_oneWait;
    endproperty
    a_waitOne: assert property (p_waitOne) else $error("bus wait not one");
    property p_rspLat;
        addrReq.valid |=> addrRsp.valid;
    endproperty
    a_rspLat: assert property (p_rspLat) else $error("response missing");
    property p_rspIdle;
        !addrReq.valid |=> !addrRsp.valid;
    endproperty
    a_rspIdle: assert property (p_rspIdle) else $error("stray response");
    property p_near;
        addrReq.valid && addrReq.cls == CLS_FILE |=> addrRsp.ea[15:13] == 3'h0;
    endproperty
    a_near: assert property (p_near) else $error("file ea too wide");
    property p_macSpace;
        addrReq.valid && addrReq.cls == CLS_MAC && !addrReq.useDst
            |=> addrRsp.ySpace == $past(addrReq.ptrSrc[1]);
    endproperty
    a_macSpace: assert property (p_macSpace) else $error("wrong space");
    property p_macIdx;
        addrReq.valid && addrReq.cls == CLS_MAC && !addrReq.useDst &&
            addrReq.srcMode == MD_INDEXED && !addrReq.ptrSrc[0]
            |=> addrRsp.err && !addrRsp.ptrWe;
    endproperty
    a_macIdx: assert property (p_macIdx) else $error("bad index taken");
    property p_noWb;
        addrReq.valid && !addrReq.useDst &&
            addrReq.srcMode inside {MD_IND, MD_INDEXED, MD_LITOFF}
            |=> !addrRsp.ptrWe;
    endproperty
    a_noWb: assert property (p_noWb) else $error("pointer written");
    property p_yWord;
        addrRsp.valid && addrRsp.ySpace && addrRsp.modApplied |-> !addrRsp.ea[0];
    endproperty
    a_yWord: assert property (p_yWord) else $error("odd y address");
    property p_hold;
        addrReq.valid && addrReq.cls == CLS_HOLD
            |=> addrRsp.litValue == {2'h0, $past(addrReq.literal[13:0])};
    endproperty
    a_hold: assert property (p_hold) else $error("hold literal");
    property p_short;
        addrReq.valid && addrReq.cls == CLS_MCU && addrReq.srcMode == MD_LIT &&
            !addrReq.useDst
            |=> addrRsp.litValue == {11'h0, $past(addrReq.literal[4:0])};
    endproperty
    a_short: assert property (p_short) else $error("short literal");
    property p_revX;
        addrRsp.valid && addrRsp.revApplied |-> !addrRsp.ySpace && !addrRsp.ea[0];
    endproperty
    a_revX: assert property (p_revX) else $error("reversal off x");
endmodule : eag_top_asserts

bind eag_top eag_top_asserts u_eag_top_asserts (.*);

// [tb/eag_top_bench.sv]
/* bench of the address generator top.
   assumes the bound checker. */
`timescale 1ns/1ps
module eag_top_bench;
    import eag_pkg::*;
    logic clk;
    logic rst_n;
    logic [4:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    eag_req_t addrReq = '0;
    eag_wr_t regWrite = '0;
    eag_rsp_t addrRsp;
    eag_rsp_t got;
    logic [31:0] rd;
    int errors = 0;
    int n_checks = 0;
    always #25 clk = ~clk;
    eag_top u_eag_top (.*);
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run;
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, logic [15:0] e, logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            errors++;
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= 4'h3;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        if (n >= 16) begin
            errors++;
            complete_run();
        end
        @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rdChk(input logic [4:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0);
        chk("readdata", e, rd[15:0]);
    endtask : rdChk
    task automatic default_working_register(input logic [3:0] i, input logic [15:0] d);
        @(posedge clk);
        regWrite <= '{1'b1, i, d};
        @(posedge clk);
        regWrite.en <= 1'b0;
    endtask : default_working_register
    task automatic req(input eag_req_t r);
        @(posedge clk);
        addrReq <= r;
        @(posedge clk);
        addrReq.valid <= 1'b0;
        #1;
        got = addrRsp;
        chk("valid", 16'h1, 16'(got.valid));
    endtask : req
    function automatic eag_req_t mk(eag_cls_t c, eag_mode_t m, logic [3:0] p,
                                    logic [15:0] md);
        eag_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.cls = c;
        r.srcMode = m;
        r.dstMode = m;
        r.ptrSrc = p;
        r.modifier = md;
        return r;
    endfunction : mk
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        rdChk(EAG_OFS_MODE_CTRL, EAG_RST_MODE_CTRL);
        bus(1'b1, EAG_OFS_X_START, 16'h0100);
        bus(1'b1, EAG_OFS_X_END, 16'h010f);
        bus(1'b1, EAG_OFS_Y_START, 16'h0200);
        bus(1'b1, EAG_OFS_Y_END, 16'h020f);
        bus(1'b1, 5'h1c, 16'h1234);
        bus(1'b1, EAG_OFS_MODE_CTRL, 16'hcfa1);
        rdChk(EAG_OFS_X_END, 16'h010f);
        rdChk(EAG_OFS_Y_START, 16'h0200);
        rdChk(EAG_OFS_MODE_CTRL, 16'hcfa1);
        rdChk(5'h1c, 16'h0000);
    endtask : t_regs
    task automatic t_modx;
        eag_req_t r;
        default_working_register(4'h1, 16'h010e);
        req(mk(CLS_MOVE, MD_POST, 4'h1, 16'h0002));
        chk("ea", 16'h010e, got.ea);
        chk("ptr", 16'h0100, got.ptrValue);
        req(mk(CLS_MOVE, MD_POST, 4'h1, 16'hfffe));
        chk("ptr", 16'h010e, got.ptrValue);
        default_working_register(4'h1, 16'h010c);
        req(mk(CLS_MOVE, MD_POST, 4'h1, 16'h0006));
        chk("ptr", 16'h0102, got.ptrValue);
        req(mk(CLS_MOVE, MD_PRE, 4'h1, 16'hfffc));
        chk("ea", 16'h010e, got.ea);
        default_working_register(4'h2, 16'h0004);
        r = mk(CLS_MOVE, MD_INDEXED, 4'h1, 16'h0);
        r.offReg = 4'h2;
        req(r);
        chk("ea", 16'h0102, got.ea);
        chk("ptrWe", 16'h0, 16'(got.ptrWe));
    endtask : t_modx
    task automatic t_xoff;
        logic [15:0] c[2];
        c = '{16'h4fa1, 16'hcfaf};
        foreach (c[i]) begin
            bus(1'b1, EAG_OFS_MODE_CTRL, c[i]);
            default_working_register(4'h1, 16'h010e);
            req(mk(CLS_MOVE, MD_POST, 4'h1, 16'h0002));
            chk("ptr", 16'h0110, got.ptrValue);
        end
    endtask : t_xoff
    task automatic t_mac;
        eag_req_t r;
        default_working_register(4'ha, 16'h020c);
        r = mk(CLS_MAC, MD_POST, 4'ha, 16'h0);
        r.macStep = 2'h3;
        req(r);
        chk("ySpace", 16'h1, 16'(got.ySpace));
        chk("ptr", 16'h0202, got.ptrValue);
        default_working_register(4'h8, 16'h0300);
        r = mk(CLS_MAC, MD_POST, 4'h8, 16'h0);
        r.macStep = 2'h1;
        req(r);
        chk("ySpace", 16'h0, 16'(got.ySpace));
        chk("ptr", 16'h0302, got.ptrValue);
        r = mk(CLS_MAC, MD_INDEXED, 4'h8, 16'h0);
        r.offReg = 4'h2;
        req(r);
        chk("err", 16'h1, 16'(got.err));
        r.ptrSrc = 4'hb;
        req(r);
        chk("err", 16'h0, 16'(got.err));
    endtask : t_mac
    task automatic t_lits;
        eag_req_t r;
        default_working_register(4'h0, 16'h1234);
        r = mk(CLS_FILE, MD_FILE, 4'h0, 16'h0);
        r.fileAddr = 13'h1abc;
        req(r);
        chk("ea", 16'h1abc, got.ea);
        chk("work", 16'h1234, got.workValue);
        r = mk(CLS_MOVE, MD_FILE, 4'h0, 16'h0);
        r.literal = 16'habcd;
        req(r);
        chk("ea", 16'habcd, got.ea);
        r = mk(CLS_MCU, MD_LIT, 4'h0, 16'h0);
        r.literal = 16'hffff;
        req(r);
        chk("lit", 16'h001f, got.litValue);
        r.cls = CLS_HOLD;
        req(r);
        chk("lit", 16'h3fff, got.litValue);
        r = mk(CLS_MCU, MD_IND, 4'h2, 16'h0);
        req(r);
        chk("base", 16'h1234, got.baseValue);
        chk("ea", 16'h0004, got.ea);
    endtask : t_lits
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_modx();
        t_xoff();
        t_mac();
        t_lits();
        complete_run();
    end
endmodule : eag_top_bench
